// file: epe_cfg.svh
// Constants of the nonvolatile program / erase controller.
// Assumes a 200 MHz clk_sys and an APB register bus with 32-bit data.
`ifndef EPE_CFG_SVH
`define EPE_CFG_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define EPE_IDX_CTL      16'h103B
`define EPE_IDX_AUX      16'h103C
`define EPE_IDX_OPT      16'h103F
`define EPE_IDX_ARR_LO   16'hB600
`define EPE_IDX_ARR_HI   16'hB7FF
`define EPE_ADDR_W       18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPE_CTL_BYTE     4
`define EPE_CTL_ROW      3
`define EPE_CTL_ERASE    2
`define EPE_CTL_LAT      1
`define EPE_CTL_HV       0
`define EPE_OPT_SEC_DIS  3
`define EPE_OPT_NOWD     2
`define EPE_OPT_ROM      1
`define EPE_OPT_ARR      0
`define EPE_AUX_CPSEL    0
`define EPE_AUX_BUSY     1
`define EPE_AUX_DONE     2

// ----------------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------------
`define EPE_ERASED       8'hFF
`define EPE_ARR_BYTES    512
`define EPE_ROW_SHIFT    4
`define EPE_CLK_KHZ      200000
`define EPE_PULSE_MS     10
`define EPE_PULSE_CYC    (`EPE_PULSE_MS * `EPE_CLK_KHZ)
`define EPE_BOOT_WAIT    3'h5

`endif

// file: epe_pkg.sv
// Types of the nonvolatile program / erase controller.
// Assumes epe_cfg.svh for the numeric constants.
package epe_pkg;
    typedef enum logic [1:0] {
        ST_BOOT_WAIT = 2'b00,
        ST_SEC_ERASE = 2'b01,
        ST_RUN       = 2'b10
    } epe_state_e;

    typedef logic [7:0] epe_byte_t;
endpackage

// file: epe_sync.sv
// Three-flop input synchroniser with agreement filter.
// Assumes the pin is asynchronous to clk_sys.
module epe_sync (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Pin and filtered level
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;

    // First flop feeds only the second
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end
endmodule // epe_sync

// file: epe_timer.sv
// High-voltage pulse timer: done rises after COUNT cycles of run.
// Assumes run stays high for the whole pulse; dropping it restarts.
module epe_timer #(
    parameter int unsigned COUNT = 2000000,
    parameter int unsigned W     = $clog2(COUNT + 1)
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Pulse control
    input  wire logic run,
    output logic      done
);
    logic [W-1:0] cnt;

    // A zero count or a narrow counter would end the pulse at the wrong time
    if (COUNT < 1 || W < $clog2(COUNT + 1)) begin : g_bad_count
        $error("epe_timer: bad COUNT or W");
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn || !run) begin
            cnt  <= '0;
            done <= 1'b0;
        end else if (cnt == W'(COUNT - 1)) begin
            done <= 1'b1;
        end else begin
            cnt <= cnt + W'(1);
        end
    end
endmodule // epe_timer

// file: epe_ctl.sv
// Nonvolatile array and startup option byte program / erase controller.
// Assumes an APB master on clk_sys, mode pins from outside the clock domain,
// and a power-on strobe that marks the nonvolatile cells as factory erased.
`include "epe_cfg.svh"

// Operation
// - A program operation ignores the row and byte select bits.
// - Programming only clears bits; setting bits needs an erase.
// - Row erase uses 0E then 0F; dummy address picks the 16-byte row.
// - Byte erase uses 16 then 17; only the addressed byte erases.
// - Upper four bits of the option register read zero.
// - An unbuilt security bit always reads one.
// - Security enabled blocks expanded multiplexed modes.
// - Secure bootstrap reset erases array, RAM and option byte.
// - Watchdog disable bit zero enables the watchdog.
// - ROM enable clear frees its space, except in single-chip mode.
// - Array enable clear frees the array address space.
// - Option byte programs like an array byte; only bulk erase applies.
// - Erasing the option byte erases the whole array too.
// - Option byte changes only in test or bootstrap mode.
// - Option byte copies into working latches at every reset.
// - Option reads return latches; program writes reach the byte.
// - Control register clears on reset; fields as laid out.
// - Setting latch and high voltage in one write sets neither.
// - Array writes under high voltage are ignored.
// - The array is off the read bus during program and erase.
module epe_ctl
    import epe_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `EPE_PULSE_CYC,
    parameter bit          SEC_IMPL  = 1'b1,
    parameter bit          NEW_REV   = 1'b1
) (
    // Clock and resets
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        pwr_on_rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [17:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Mode pins
    input  wire logic        boot_mode_pin,
    input  wire logic        test_mode_pin,
    input  wire logic        single_chip_pin,
    // System controls
    output logic             operating_watchdog,
    output logic             rom_enable,
    output logic             array_enable,
    output logic             expanded_mux_allowed,
    output logic             ram_erase,
    output logic             high_voltage_on,
    output logic             charge_pump_clk_sel
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int unsigned ARR = `EPE_ARR_BYTES;

    epe_byte_t   nv_array [ARR];
    epe_byte_t   nv_option;
    logic [3:0]  opt_latch;
    logic        byte_sel;
    logic        row_sel;
    logic        erase_mode;
    logic        nvm_latch_ctl;
    logic        cap_valid;
    logic        cap_opt;
    logic [8:0]  cap_idx;
    epe_byte_t   cap_data;
    logic        committed;
    logic        pulse_done;
    logic        commit;
    epe_state_e  state;
    logic [2:0]  boot_cnt;
    logic        boot_mode;
    logic        test_mode;
    logic        single_chip;
    logic [15:0] idx;
    logic        hit_ctl;
    logic        hit_aux;
    logic        hit_opt;
    logic        hit_arr;
    logic        wr_acc;
    logic        rd_setup;
    logic        opt_write_ok;
    logic        sec_disable;
    epe_byte_t   next_rd;
    epe_byte_t   exp_byte;

    // A zero pulse length would commit with no high voltage time at all
    if (PULSE_CYC < 1) begin : g_bad_pulse
        $error("epe_ctl: PULSE_CYC must be at least one");
    end

    // ------------------------------------------------------------------
    // Mode pins and pulse timer
    // ------------------------------------------------------------------
    epe_sync u_sync_boot (.clk_sys(clk_sys), .rstn(rstn), .pin(boot_mode_pin), .level(boot_mode));
    epe_sync u_sync_test (.clk_sys(clk_sys), .rstn(rstn), .pin(test_mode_pin), .level(test_mode));
    epe_sync u_sync_sc (.clk_sys(clk_sys), .rstn(rstn), .pin(single_chip_pin),
                        .level(single_chip));

    epe_timer #(.COUNT(PULSE_CYC)) u_timer (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (high_voltage_on),
        .done    (pulse_done)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign idx          = paddr[17:2];
    assign hit_ctl      = (idx == `EPE_IDX_CTL);
    assign hit_aux      = (idx == `EPE_IDX_AUX);
    assign hit_opt      = (idx == `EPE_IDX_OPT);
    assign hit_arr      = (idx >= `EPE_IDX_ARR_LO) && (idx <= `EPE_IDX_ARR_HI)
                          && opt_latch[`EPE_OPT_ARR];
    assign wr_acc       = psel && penable && pwrite;
    assign rd_setup     = psel && !penable && !pwrite;
    assign pready       = 1'b1;
    assign pslverr      = psel && penable && !(hit_ctl || hit_aux || hit_opt || hit_arr);
    assign opt_write_ok = !NEW_REV || test_mode || boot_mode;
    assign sec_disable  = SEC_IMPL ? opt_latch[`EPE_OPT_SEC_DIS] : 1'b1;
    // A pulse cut in its last cycle must not commit with the control cleared
    assign commit       = pulse_done && !committed && high_voltage_on;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            byte_sel        <= 1'b0;
            row_sel         <= 1'b0;
            erase_mode      <= 1'b0;
            nvm_latch_ctl   <= 1'b0;
            high_voltage_on <= 1'b0;
        end else if (wr_acc && hit_ctl) begin
            byte_sel   <= pwdata[`EPE_CTL_BYTE];
            row_sel    <= pwdata[`EPE_CTL_ROW];
            erase_mode <= pwdata[`EPE_CTL_ERASE];
            // Runaway code writing 03 from read mode must not start a pulse
            if (pwdata[`EPE_CTL_LAT] && pwdata[`EPE_CTL_HV] && !nvm_latch_ctl) begin
                nvm_latch_ctl   <= 1'b0;
                high_voltage_on <= 1'b0;
            end else begin
                nvm_latch_ctl   <= pwdata[`EPE_CTL_LAT];
                high_voltage_on <= pwdata[`EPE_CTL_HV] && pwdata[`EPE_CTL_LAT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            charge_pump_clk_sel <= 1'b0;
        end else if (wr_acc && hit_aux) begin
            charge_pump_clk_sel <= pwdata[`EPE_AUX_CPSEL];
        end
    end

    // ------------------------------------------------------------------
    // Latched target of the next pulse
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cap_valid <= 1'b0;
            cap_opt   <= 1'b0;
            cap_idx   <= 9'h000;
            cap_data  <= 8'h00;
        end else if (!nvm_latch_ctl) begin
            cap_valid <= 1'b0;
        end else if (wr_acc && !high_voltage_on
                     && (hit_arr || (hit_opt && opt_write_ok))) begin
            cap_valid <= 1'b1;
            cap_opt   <= hit_opt;
            cap_idx   <= idx[8:0];
            cap_data  <= pwdata[7:0];
        end
    end

    // One commit per pulse; cleared when high voltage drops
    always_ff @(posedge clk_sys) begin
        if (!rstn || !high_voltage_on) begin
            committed <= 1'b0;
        end else if (pulse_done) begin
            committed <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile cells (kept across rstn)
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!pwr_on_rstn) begin
            nv_option <= `EPE_ERASED;
            for (int i = 0; i < ARR; i++) begin
                nv_array[i] <= `EPE_ERASED;
            end
        end else if (state == ST_SEC_ERASE) begin
            nv_option <= `EPE_ERASED;
            for (int i = 0; i < ARR; i++) begin
                nv_array[i] <= `EPE_ERASED;
            end
        end else if (commit && cap_valid) begin
            if (!erase_mode) begin
                // Program ignores row and byte selects
                if (cap_opt) begin
                    nv_option <= nv_option & cap_data;
                end else begin
                    nv_array[cap_idx] <= nv_array[cap_idx] & cap_data;
                end
            end else if (cap_opt) begin
                // Option byte takes bulk erase only, and drags the array along
                if (!byte_sel && !row_sel) begin
                    nv_option <= `EPE_ERASED;
                    for (int i = 0; i < ARR; i++) begin
                        nv_array[i] <= `EPE_ERASED;
                    end
                end
            end else if (byte_sel) begin
                nv_array[cap_idx] <= `EPE_ERASED;
            end else begin
                for (int i = 0; i < ARR; i++) begin
                    if (!row_sel || (9'(i) >> `EPE_ROW_SHIFT)
                                    == (cap_idx >> `EPE_ROW_SHIFT)) begin
                        nv_array[i] <= `EPE_ERASED;
                    end
                end
            end
        end
    end

    // Working latches follow the byte only while reset is held
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            opt_latch <= nv_option[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Reset-time security check
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state     <= ST_BOOT_WAIT;
            boot_cnt  <= 3'h0;
            ram_erase <= 1'b0;
        end else begin
            ram_erase <= 1'b0;
            case (state)
                ST_BOOT_WAIT: begin
                    // Waits for the mode pins to pass the synchronisers
                    boot_cnt <= boot_cnt + 3'h1;
                    if (boot_cnt == `EPE_BOOT_WAIT) begin
                        if (boot_mode && !sec_disable) begin
                            state     <= ST_SEC_ERASE;
                            ram_erase <= 1'b1;
                        end else begin
                            state <= ST_RUN;
                        end
                    end
                end
                ST_SEC_ERASE: state <= ST_RUN;
                ST_RUN:       state <= ST_RUN;
                default:      state <= ST_BOOT_WAIT;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read data and system outputs
    // ------------------------------------------------------------------
    always_comb begin
        next_rd = 8'h00;
        if (hit_ctl) begin
            next_rd = {3'h0, byte_sel, row_sel, erase_mode, nvm_latch_ctl, high_voltage_on};
        end else if (hit_aux) begin
            next_rd = {5'h00, committed, high_voltage_on, charge_pump_clk_sel};
        end else if (hit_opt) begin
            next_rd = {4'h0, sec_disable, opt_latch[2:0]};
        end else if (hit_arr && !nvm_latch_ctl) begin
            next_rd = nv_array[idx[8:0]];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {24'h00_0000, next_rd};
        end
    end

    assign operating_watchdog   = !opt_latch[`EPE_OPT_NOWD];
    assign rom_enable           = opt_latch[`EPE_OPT_ROM] || single_chip;
    assign array_enable         = opt_latch[`EPE_OPT_ARR];
    assign expanded_mux_allowed = sec_disable;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        exp_byte <= nv_array[cap_idx] & cap_data;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_ctl_reset_clear: assert property (disable iff (1'b0)
        !rstn |=> !nvm_latch_ctl && !high_voltage_on && !erase_mode && !row_sel && !byte_sel)
        else $error("control register not cleared by reset");
    a_both_bits_refused: assert property (
        wr_acc && hit_ctl && pwdata[1:0] == 2'h3 && !nvm_latch_ctl
        |=> !nvm_latch_ctl && !high_voltage_on)
        else $error("latch and high voltage set by one write");
    a_hv_write_ignored: assert property (
        wr_acc && hit_arr && high_voltage_on |=> $stable(cap_idx) && $stable(cap_data))
        else $error("array write under high voltage disturbed target");
    a_arr_read_block: assert property (
        rd_setup && hit_arr && nvm_latch_ctl |=> prdata == 32'h0000_0000)
        else $error("array visible on read bus during operation");
    a_opt_upper_zero: assert property (
        rd_setup && hit_opt |=> prdata[7:4] == 4'h0 && prdata[3:0] == {sec_disable, opt_latch[2:0]})
        else $error("option register read wrong");
    a_prog_and_only: assert property (
        commit && cap_valid && !erase_mode && !cap_opt ##1 1'b1
        |-> nv_array[cap_idx] == exp_byte)
        else $error("program set a bit");
    a_opt_guard: assert property (
        wr_acc && hit_opt && nvm_latch_ctl && !high_voltage_on && !opt_write_ok
        |=> $stable(cap_valid) && $stable(cap_opt))
        else $error("option write accepted outside test or boot");
    a_latch_hold: assert property (
        $past(rstn) |-> $stable(opt_latch))
        else $error("option latches changed outside reset");
    a_opt_erase_all: assert property (
        commit && cap_valid && erase_mode && cap_opt && !row_sel && !byte_sel
        |=> nv_option == `EPE_ERASED && nv_array[0] == `EPE_ERASED
            && nv_array[ARR-1] == `EPE_ERASED)
        else $error("option erase left array cells");
    a_sec_ram_erase: assert property (
        state == ST_SEC_ERASE |-> ram_erase ##1 state == ST_RUN && !ram_erase)
        else $error("secure boot erase sequence broken");

    c_program: cover property (commit && cap_valid && !erase_mode);
    c_row_erase: cover property (commit && cap_valid && erase_mode && row_sel && !byte_sel);
    c_opt_bulk: cover property (commit && cap_valid && erase_mode && cap_opt);
    c_sec_erase: cover property (state == ST_SEC_ERASE);
endmodule // epe_ctl

// file: epe_ctl_bench.sv
// Self-checking bench for the nonvolatile program / erase controller.
// Assumes epe_ctl with a short pulse count and an APB master driven from here.
`include "epe_cfg.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

module epe_ctl_bench
    import epe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Map and signals
    // ------------------------------------------------------------------
    localparam int unsigned PULSE = 20;
    localparam logic [17:0] CTL   = 18'(`EPE_IDX_CTL) << 2;
    localparam logic [17:0] AUX   = 18'(`EPE_IDX_AUX) << 2;
    localparam logic [17:0] OPT   = 18'(`EPE_IDX_OPT) << 2;
    localparam logic [17:0] ARR   = 18'(`EPE_IDX_ARR_LO) << 2;
    logic clk_sys = 0, rstn = 0, pwr_on_rstn = 0;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, e, wdog, rom_en, arr_en, mux_ok, ram_er, hv, cp_sel;
    logic boot_pin = 0, test_pin = 0, chip_pin = 0;
    int n_errors = 0;
    int comparisons = 0;
    int n_ram = 0;

    always #2.5 clk_sys = ~clk_sys;

    // Counts secure boot erase pulses on the RAM clear output
    always @(posedge clk_sys) begin
        if (ram_er === 1'b1) n_ram <= n_ram + 1;
    end

    epe_ctl #(.PULSE_CYC(PULSE)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .pwr_on_rstn(pwr_on_rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .boot_mode_pin(boot_pin), .test_mode_pin(test_pin), .single_chip_pin(chip_pin),
        .operating_watchdog(wdog), .rom_enable(rom_en), .array_enable(arr_en),
        .expanded_mux_allowed(mux_ok), .ram_erase(ram_er), .high_voltage_on(hv),
        .charge_pump_clk_sel(cp_sel));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            give_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask

    task automatic chk_rd(input string nm, input logic [17:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        `CHK(nm, ex, q)
    endtask

    // Full sequence: arm, target write, high voltage, wait for commit, clear
    task automatic op(input logic [7:0] mode, input logic [17:0] a, input logic [7:0] d);
        int i;
        wr(CTL, mode);
        wr(a, d);
        chk_rd("read while armed", ARR + 18'h4, 32'h0);
        wr(CTL, mode | 8'h01);
        // High voltage rises on the access edge of the write that sets it; checked one edge later
        @(posedge clk_sys);
        `CHK("high voltage", 1'b1, hv)
        wr(ARR, 8'h00);
        q = '0;
        for (i = 0; i < 40 && q[`EPE_AUX_DONE] !== 1'b1; i++) xfer(1'b0, AUX, 32'h0);
        if (i == 40) begin
            n_errors++;
            give_verdict();
        end
        wr(CTL, 8'h00);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (10) @(posedge clk_sys);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        @(posedge clk_sys);
        pwr_on_rstn <= 1'b1;
        @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk_rd("ctl reset", CTL, 32'h0);
        chk_rd("option", OPT, 32'h0F);
        `CHK("watchdog", 1'b0, wdog)
        `CHK("array on", 1'b1, arr_en)
        wr(AUX, 8'h01);
        @(posedge clk_sys);
        `CHK("pump clock", 1'b1, cp_sel)
        wr(CTL, 8'h03);
        chk_rd("latch and hv", CTL, 32'h0);
        op(8'h02, ARR + 18'h40, 8'h55);
        op(8'h1A, ARR + 18'h40, 8'hF0);
        chk_rd("program", ARR + 18'h40, 32'h50);
        op(8'h02, ARR + 18'h80, 8'h0F);
        op(8'h02, ARR + 18'h44, 8'h33);
        op(8'h16, ARR + 18'h44, 8'h00);
        chk_rd("byte erased", ARR + 18'h44, 32'hFF);
        chk_rd("byte kept", ARR + 18'h40, 32'h50);
        op(8'h0E, ARR + 18'h7C, 8'h12);
        chk_rd("row erased", ARR + 18'h40, 32'hFF);
        chk_rd("row kept", ARR + 18'h80, 32'h0F);
        chk_rd("hv write", ARR, 32'hFF);
        op(8'h06, ARR + 18'h10, 8'h00);
        chk_rd("bulk", ARR + 18'h80, 32'hFF);
        op(8'h02, ARR, 8'h00);
        op(8'h02, OPT, 8'h0D);
        test_pin <= 1'b1;
        op(8'h02, OPT, 8'h02);
        chk_rd("latches", OPT, 32'h0F);
        op(8'h16, OPT, 8'h00);
        do_reset();
        chk_rd("new option", OPT, 32'h02);
        `CHK("watchdog on", 1'b1, wdog)
        `CHK("mux blocked", 1'b0, mux_ok)
        `CHK("array off", 1'b0, arr_en)
        `CHK("rom on", 1'b1, rom_en)
        xfer(1'b0, ARR, 32'h0);
        `CHK("array unmapped", 1'b1, e)
        op(8'h06, OPT, 8'h00);
        do_reset();
        chk_rd("option erased", OPT, 32'h0F);
        chk_rd("array erased", ARR, 32'hFF);
        // Secure option byte with ROM off, then a bootstrap reset
        op(8'h02, ARR, 8'h3C);
        op(8'h02, OPT, 8'h05);
        boot_pin <= 1'b1;
        do_reset();
        `CHK("ram erase", 1, n_ram)
        chk_rd("secure erase", ARR, 32'hFF);
        chk_rd("latch kept", OPT, 32'h05);
        `CHK("rom off", 1'b0, rom_en)
        chip_pin <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK("rom single chip", 1'b1, rom_en)
        give_verdict();
    end
endmodule // epe_ctl_bench
